// ### logic/ats_trigger_select.v
// Converter sample trigger source selector with control register
`timescale 1ns/1ns
`default_nettype none
`include "ats_map.vh"

// Overview of operation
// (R1) Source select held in bits 7:5
// (R2) Group set: codes 0-2 pick PWM generators
// (R3) Group set: codes 3-6 pick pattern outputs
// (R4) Group clear, code 7: internal counter auto-convert
// (R5) Group clear, code 6: charge-time unit triggers
// (R6) Group clear, code 4: timer five compare
// (R7) Group clear, code 3: PWM special event
// (R8) Group clear, code 2: timer three compare
// (R9) Group clear, code 1: external pin edge
// (R10) Manual: software clearing sample bit converts
// (R11) Group bit at position 4 picks table
// (R12) Hardware clears sample bit on selected event
// (R13) Reserved codes produce no trigger
module ats_trigger_select #(
  parameter CONV_CYCLES = `ATS_CONV_CYCLES
) (
  input  wire                    clk,
  input  wire                    reset,
  input  wire [`ATS_ADDR_W-1:0]  reg_addr,
  input  wire [15:0]             reg_wdata,
  input  wire                    reg_write,
  input  wire                    reg_read,
  output reg  [15:0]             reg_rdata,
  input  wire [2:0]              pwm_gen_trigger,
  input  wire                    pattern_trigger_output_12,
  input  wire                    pattern_trigger_output_13,
  input  wire                    pattern_trigger_output_14,
  input  wire                    pattern_trigger_output_15,
  input  wire                    charge_time_measure_unit,
  input  wire                    timer_five,
  input  wire                    timer_three,
  input  wire                    pwm_special_event,
  input  wire                    external_interrupt_pin_zero,
  output reg                     sample_active,
  output reg                     conversion_start,
  output reg                     converting
);
  reg        module_enable;
  reg [2:0]  trigger_source_select;
  reg        trigger_source_group;
  reg        auto_sample;
  reg        sample_active_bit;
  reg        done_bit;
  reg [7:0]  auto_count_limit;
  reg [7:0]  auto_count;
  reg [7:0]  conv_count;
  reg        event_hit;
  reg        next_sample;
  reg        next_start;
  reg        sw_clear_sample_active_bit;
  reg        sw_set_sample_active_bit;
  wire       ext_rise;
  wire       conv_end;

  // Pin edge comes from outside the clock domain
  ats_edge_sync u_ext_sync (
    .clk        (clk),
    .reset      (reset),
    .pin_in     (external_interrupt_pin_zero),
    .rise_pulse (ext_rise)
  );

  // Table lookup; reserved codes give no event
  function sel_event;
    input       grp;
    input [2:0] code;
    input [2:0] pwm;
    input [3:0] pat;
    input       charge;
    input       t5;
    input       spec;
    input       t3;
    input       ext;
    input       cnt_hit;
    begin
      sel_event = 1'b0;
      if (grp) begin // R11
        case (code)
          3'h0: sel_event = pwm[0]; // R2
          3'h1: sel_event = pwm[1]; // R2
          3'h2: sel_event = pwm[2]; // R2
          3'h3: sel_event = pat[0]; // R3
          3'h4: sel_event = pat[1]; // R3
          3'h5: sel_event = pat[2]; // R3
          3'h6: sel_event = pat[3]; // R3
          default: sel_event = 1'b0; // R13
        endcase
      end else begin
        case (code)
          `ATS_CODE_AUTO:     sel_event = cnt_hit; // R4
          `ATS_CODE_CHARGE:   sel_event = charge; // R5
          `ATS_CODE_TIMER_FIVE:   sel_event = t5; // R6
          `ATS_CODE_SPECIAL:  sel_event = spec; // R7
          `ATS_CODE_TIMER_THREE:   sel_event = t3; // R8
          `ATS_CODE_EXT_INT:  sel_event = ext; // R9
          default:            sel_event = 1'b0; // R13
        endcase
      end
    end
  endfunction

  wire manual_mode = ~trigger_source_group &&
                     (trigger_source_select == `ATS_CODE_MANUAL);
  wire ctrl_write  = reg_write && (reg_addr == `ATS_OFF_CTRL_ONE);
  // Enable written in the same cycle as the sample bit must count
  wire enable_now  = ctrl_write ? reg_wdata[`ATS_BIT_ENABLE] : module_enable;
  wire cnt_hit     = (auto_count >= auto_count_limit);

  assign conv_end = converting && (conv_count == 8'h00);

  always @* begin
    event_hit = sel_event(trigger_source_group, trigger_source_select,
                          pwm_gen_trigger,
                          {pattern_trigger_output_15, pattern_trigger_output_14,
                           pattern_trigger_output_13, pattern_trigger_output_12},
                          charge_time_measure_unit, timer_five, pwm_special_event,
                          timer_three, ext_rise, cnt_hit);
    sw_clear_sample_active_bit = ctrl_write && ~reg_wdata[`ATS_BIT_SAMPLE_ACTIVE_BIT];
    sw_set_sample_active_bit   = ctrl_write && reg_wdata[`ATS_BIT_SAMPLE_ACTIVE_BIT];
    next_sample = sample_active_bit;
    next_start  = 1'b0;
    if (module_enable && sample_active_bit) begin
      if (manual_mode && sw_clear_sample_active_bit) begin
        next_sample = 1'b0; // R10
        next_start  = 1'b1; // R10
      end else if (!manual_mode && event_hit) begin
        next_sample = 1'b0; // R12
        next_start  = 1'b1; // R12
      end else if (sw_clear_sample_active_bit) begin
        next_sample = 1'b0;
      end
    end else if (sw_set_sample_active_bit && !converting) begin
      next_sample = 1'b1;
    end
    // Auto-sample restarts sampling once a conversion finishes
    if (conv_end && auto_sample && module_enable) begin
      next_sample = 1'b1;
    end
    if (!enable_now) begin
      next_sample = 1'b0;
      next_start  = 1'b0;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      module_enable         <= 1'b0;
      trigger_source_select <= 3'h0;
      trigger_source_group  <= 1'b0;
      auto_sample           <= 1'b0;
      auto_count_limit      <= `ATS_AUTO_CNT_RESET;
    end else if (reg_write) begin
      if (reg_addr == `ATS_OFF_CTRL_ONE) begin
        module_enable         <= reg_wdata[`ATS_BIT_ENABLE];
        trigger_source_select <= reg_wdata[`ATS_SEL_HI:`ATS_SEL_LO]; // R1
        trigger_source_group  <= reg_wdata[`ATS_BIT_GROUP]; // R11
        auto_sample           <= reg_wdata[`ATS_BIT_ASAM];
      end else if (reg_addr == `ATS_OFF_AUTO_CNT) begin
        auto_count_limit <= reg_wdata[7:0];
      end
    end
  end

  // Counter runs only while sampling, so each sample gets a full window
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      auto_count <= 8'h00;
    end else if (!sample_active_bit) begin
      auto_count <= 8'h00;
    end else if (!cnt_hit) begin
      auto_count <= auto_count + 8'h01; // R4
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sample_active_bit <= 1'b0;
      sample_active     <= 1'b0;
      conversion_start  <= 1'b0;
      converting        <= 1'b0;
      conv_count        <= 8'h00;
      done_bit          <= 1'b0;
    end else begin
      sample_active_bit <= next_sample;
      sample_active     <= next_sample;
      conversion_start  <= next_start;
      if (next_start) begin
        converting <= 1'b1;
        conv_count <= CONV_CYCLES[7:0];
      end else if (conv_end) begin
        converting <= 1'b0;
      end else if (converting) begin
        conv_count <= conv_count - 8'h01;
      end
      // Completion set wins over a software clear in the same cycle
      if (conv_end) begin
        done_bit <= 1'b1;
      end else if (next_start) begin
        done_bit <= 1'b0;
      end else if (ctrl_write && ~reg_wdata[`ATS_BIT_DONE]) begin
        done_bit <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        `ATS_OFF_CTRL_ONE: reg_rdata <= {module_enable, 7'h00, trigger_source_select,
                                         trigger_source_group, 1'b0, auto_sample,
                                         sample_active_bit, done_bit};
        `ATS_OFF_AUTO_CNT: reg_rdata <= {8'h00, auto_count_limit};
        `ATS_OFF_STATUS:   reg_rdata <= {14'h0000, converting, sample_active_bit};
        default:           reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ### logic/ats_map.vh
// Register offsets, field positions and reset values for the sample trigger selector
`ifndef ATS_MAP_VH
`define ATS_MAP_VH
`define ATS_ADDR_W          4
`define ATS_OFF_CTRL_ONE    4'h0
`define ATS_OFF_AUTO_CNT    4'h4
`define ATS_OFF_STATUS      4'h8
`define ATS_BIT_DONE        0
`define ATS_BIT_SAMPLE_ACTIVE_BIT        1
`define ATS_BIT_ASAM        2
`define ATS_BIT_GROUP       4
`define ATS_SEL_LO          5
`define ATS_SEL_HI          7
`define ATS_BIT_ENABLE      15
`define ATS_CTRL_RESET      16'h0000
`define ATS_AUTO_CNT_RESET  8'h1f
`define ATS_CONV_CYCLES     8'h0e
`define ATS_CODE_MANUAL     3'h0
`define ATS_CODE_EXT_INT    3'h1
`define ATS_CODE_TIMER_THREE     3'h2
`define ATS_CODE_SPECIAL    3'h3
`define ATS_CODE_TIMER_FIVE     3'h4
`define ATS_CODE_RESERVED   3'h5
`define ATS_CODE_CHARGE     3'h6
`define ATS_CODE_AUTO       3'h7
`endif

// ### logic/ats_edge_sync.v
// Two-stage synchroniser with rising-edge pulse for one asynchronous pin
`timescale 1ns/1ns
`default_nettype none
module ats_edge_sync (
  input  wire clk,
  input  wire reset,
  input  wire pin_in,
  output reg  rise_pulse
);
  reg meta;
  reg stable;
  reg stable_d;

  // Only the second stage feeds the edge detector
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta       <= 1'b0;
      stable     <= 1'b0;
      stable_d   <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      meta       <= pin_in;
      stable     <= meta;
      stable_d   <= stable;
      rise_pulse <= stable & ~stable_d;
    end
  end
endmodule
`default_nettype wire

// ### verif/ats_source_model.sv
// Far-side event sources: PWM, pattern outputs, timers, charge unit and pin
`timescale 1ns/1ns
`default_nettype none
module ats_source_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        go,
  input  wire logic [11:0] mask,
  output logic      [11:0] src
);
  // One-cycle pulses on the system clock; idle low between events
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      src <= 12'h000;
    end else begin
      src <= go ? mask : 12'h000;
    end
  end
endmodule
`default_nettype wire

// ### verif/ats_trigger_select_properties.sv
// Assertions on the sample trigger selector ports
`timescale 1ns/1ns
`default_nettype none
module ats_trigger_checker #(parameter CONV_CYCLES = 2) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        charge_time_measure_unit,
  input wire logic        timer_five,
  input wire logic        timer_three,
  input wire logic        pwm_special_event,
  input wire logic        sample_active,
  input wire logic        conversion_start,
  input wire logic        converting
);
  logic [15:0] ctrl;
  logic [7:0]  run;
  wire  [7:0]  src = {1'b0, charge_time_measure_unit, 1'b0, timer_five,
                      pwm_special_event, timer_three, 2'b00};
  wire         wr0 = reg_write && reg_addr == 4'h0;
  wire         quiet = sample_active && !reg_write && ctrl[15] && !ctrl[4];
  // Control word rebuilt from bus writes, so no internal probing is needed
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= 16'h0000;
      run  <= 8'h00;
    end else begin
      ctrl <= wr0 ? reg_wdata : ctrl;
      run  <= converting ? run + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_once;
    conversion_start ##1 !conversion_start;
  endsequence
  start_once_a: assert property (
    conversion_start |-> s_once) else $error("start pulse too long");
  start_ends_sample_a: assert property (
    conversion_start |-> !sample_active && $past(sample_active)) else $error("bad start");
  sample_drop_a: assert property (
    $fell(sample_active) && !$past(reg_write) |-> conversion_start) else $error("drop");
  conv_with_start_a: assert property (
    $rose(converting) |-> conversion_start) else $error("converting without start");
  conv_length_a: assert property (
    $fell(converting) |-> run == CONV_CYCLES + 1) else $error("conversion length");
  clear_table_a: assert property (
    quiet && src[ctrl[7:5]] |=> conversion_start) else $error("trigger missed");
  reserved_quiet_a: assert property (
    quiet && ctrl[7:5] == 3'h5 |=> !conversion_start) else $error("reserved fired");
  manual_clear_a: assert property (
    sample_active && wr0 && reg_wdata[15] && reg_wdata[7:4] == 4'h0 && !reg_wdata[1]
    |=> conversion_start) else $error("manual clear missed");
endmodule
bind ats_trigger_select ats_trigger_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);
`default_nettype wire

// ### verif/test_ats_trigger_select.sv
// Self-checking bench for the sample trigger selector
`timescale 1ns/1ns
`default_nettype none
module test_ats_trigger_select;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        go = 1'b0;
  logic [11:0] mask = 12'h000;
  logic [11:0] src;
  logic [15:0] reg_rdata;
  logic        sample_active, conversion_start, converting, seen;
  logic [16:0] c;
  int          miscompares = 0;
  int          num_checks = 0;
  // Case word: expect start, group, code, source mask
  logic [16:0] tbl [16] = '{17'h18001, 17'h19002, 17'h1a004,
    17'h1b008, 17'h1c010, 17'h1d020, 17'h1e040, 17'h0ffff,
    17'h10000, 17'h11800, 17'h12400, 17'h13200,
    17'h14100, 17'h05fff, 17'h16080, 17'h17000};
  ats_source_model u_src (.*);
  ats_trigger_select #(.CONV_CYCLES(2)) u_dut (.*, .pwm_gen_trigger(src[2:0]),
    .pattern_trigger_output_12(src[3]), .pattern_trigger_output_13(src[4]),
    .pattern_trigger_output_14(src[5]), .pattern_trigger_output_15(src[6]),
    .charge_time_measure_unit(src[7]), .timer_five(src[8]), .pwm_special_event(src[9]),
    .timer_three(src[10]), .external_interrupt_pin_zero(src[11]));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  task automatic fire(input logic [11:0] m);
    @(posedge clk);
    mask <= m;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Look 1 ns past each edge so the one-cycle pulse is never missed
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      #1;
      if (conversion_start === 1'b1) seen = 1'b1;
      @(posedge clk);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h001f);
    rd(4'hc, 16'h0000);
    foreach (tbl[i]) begin
      c = tbl[i];
      wr(4'h0, {8'h80, c[14:12], c[15], 4'h2});
      // Other sources must not end sampling; auto mode would, so it is skipped
      if (c[16] && c[15:12] != 4'h7) begin
        fire(~c[11:0]);
        watch(8);
        chk({15'h0, seen}, 16'h0000);
      end
      if (c[15:12] == 4'h0) wr(4'h0, 16'h8000);
      else fire(c[11:0]);
      watch(40);
      chk({15'h0, seen}, {15'h0, c[16]});
      if (!c[16]) rd(4'h8, 16'h0001);
      rd(4'h0, {8'h80, c[14:12], c[15], 2'b00, ~c[16], c[16]});
    end
    give_verdict;
  end
endmodule
`default_nettype wire
